// ===== cgcc_top.sv
/*
 * Command-addressed global configuration and status registers of a four-channel codec,
 * reached over the serial microprocessor port (select, clock, data in, data out).
 * Assumes the port pins are asynchronous to sys_clk and that each clock half period of the
 * host lasts at least eight sys_clk cycles.
 */
// Summary of operation
// R1 - Clock-slot register at 44h write, 45h read
// R2 - Both-highway bit transmits on A and B
// R3 - Launch edge bit picks falling or rising
// R4 - Receive and transmit clock slots, three bits each
// R5 - Clock-slot access needs an enabled channel
// R6 - Interrupt output push-pull or open drain
// R7 - Chopper clock 2048 kHz over 8 or 7
// R8 - Signaling bit carries signaling on highway
// R9 - Clock source pin versus bit clock, E1
// R10 - Master frequency code decode, reserved codes
// R11 - Configuration commands ignore channel enables
// R12 - Robbed-bit signaling only with mu-law
// R13 - Idle analog output resistor tie or float
// R14 - Low power only while all channels idle
// R15 - Four channel enable bits, reset to one
// R16 - Real-time read 4Dh keeps, 4Fh clears
// R17 - Real-time byte interleaves A and B inputs
// R18 - Transmit gain and receive loss 6.02 dB
// R19 - Scaling gain 0.0625 times field minus 16
// R20 - Field 16 loopback, zero means cutoff
// R21 - Output latch driven only on output pins
// R22 - Muxed second output only with E1 mode
// R23 - Per-pin direction bits, input after reset
// R24 - Host writes zeros to reserved bits
`timescale 1ns/1ps

module cgcc_top
    import cgcc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Serial command port
    input  wire logic        portSelectN,
    input  wire logic        portClock,
    input  wire logic        portDataIn,
    output logic             portDataOut,
    output logic             portDataOutEnN,
    // Device state seen by this block
    input  wire logic        muLawSelected,
    input  wire logic [3:0]  channelActive,
    input  wire logic        e1MuxEnable,
    input  wire logic [3:0]  debouncedInputA,
    input  wire logic [3:0]  secondInputB,
    // SLIC I/O pins
    input  wire logic [4:0]  slicIoIn,
    output logic      [4:0]  slicIoOut,
    output logic      [4:0]  slicIoEnN,
    output logic             muxedOutputB,
    // PCM and clock controls
    output logic             txBothHighways,
    output logic             txLaunchRising,
    output logic      [2:0]  rxClockSlot,
    output logic      [2:0]  txClockSlot,
    output logic             irqOpenDrain,
    output logic             pcmSignalingOn,
    output logic             masterFromBitClock,
    output logic             e1MuxPermitted,
    output logic      [13:0] masterFreqKhz,
    output logic             masterFreqValid,
    output logic             chopperClk,
    output logic             chopperTick,
    // Channel and analog controls
    output logic      [3:0]  channelAcceptFlags,
    output logic             robbedSignalingActive,
    output logic             lowPowerActive,
    output logic      [3:0]  analogOutputToRef,
    output logic      [3:0]  analogOutputHiZ,
    output logic             txGainBoost,
    output logic             rxLossInsert,
    output logic signed [5:0] aisnGainSteps,
    output logic             aisnCutoff,
    output logic             digitalLoopback,
    output logic             irqClearPulse
);

    // Plain decimal kHz of the decoded master clock; zero for reserved codes.
    function automatic logic [13:0] freqDecode(input logic [3:0] code);
        logic [13:0] base;
        base = 14'h0000;
        unique case (code[1:0])
            2'h0: base = FREQ_BASE_A;
            2'h1: base = FREQ_BASE_B;
            2'h2: base = FREQ_BASE_C;
            2'h3: base = 14'h0000;
        endcase
        unique case (code[3:2])
            2'h0: freqDecode = base;
            2'h1: freqDecode = base << 1;
            2'h2: freqDecode = base << 2;
            2'h3: freqDecode = 14'h0000;
        endcase
    endfunction

    // Which phase follows a command byte.
    function automatic cgcc_state_type cmdPhase(input logic [7:0] cmd, input logic chanOk);
        unique case (cmd)
            CMD_SLOT_WR:                          cmdPhase = chanOk ? ST_DATA_WRITE : ST_IGNORE;
            CMD_SLOT_RD:                          cmdPhase = chanOk ? ST_DATA_READ : ST_IGNORE;
            CMD_CFG_WR, CMD_CHEN_WR, CMD_IMPEDANCE_SCALING_COEF_WR,
            CMD_SLIC_WR, CMD_DIR_WR:              cmdPhase = ST_DATA_WRITE;
            CMD_CFG_RD, CMD_CHEN_RD, CMD_IMPEDANCE_SCALING_COEF_RD,
            CMD_SLIC_RD, CMD_DIR_RD,
            CMD_RTD_RD, CMD_RTD_CLR:              cmdPhase = ST_DATA_READ;
            default:                              cmdPhase = ST_COMMAND;
        endcase
    endfunction

    cgcc_slot_type  slotReg;
    cgcc_cfg_type   cfgReg;
    cgcc_chen_type  chenReg;
    cgcc_impedance_scaling_coef_type  aisnReg;
    cgcc_slic_type  slicReg;
    logic [4:0]     dirReg;
    cgcc_state_type stateReg;
    cgcc_state_type phaseNext;
    logic [7:0]     cmdReg;
    logic [2:0]     pinS1;
    logic [2:0]     pinS2;
    logic [2:0]     pinS3;
    logic [2:0]     pinLvl;
    logic           sclkPrev;
    logic [2:0]     bitCnt;
    logic [6:0]     shiftIn;
    logic [6:0]     txShift;
    logic           skipFall;
    logic           selected;
    logic           sclkRise;
    logic           sclkFall;
    logic           byteDone;
    logic [7:0]     byteValue;
    logic           cmdDone;
    logic           writeStrobe;
    logic [7:0]     rtdValue;
    logic [7:0]     readValue;
    logic [16:0]    chopAcc;
    logic [2:0]     chopCnt;
    logic [16:0]    chopSum;
    logic           baseTick;

    // Three-stage synchroniser; a level is accepted once stages two and three agree.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            pinS1    <= 3'h7;
            pinS2    <= 3'h7;
            pinS3    <= 3'h7;
            pinLvl   <= 3'h7;
            sclkPrev <= 1'b1;
        end
        else
        begin
            pinS1    <= {portSelectN, portClock, portDataIn};
            pinS2    <= pinS1;
            pinS3    <= pinS2;
            for (int i = 0; i < 3; i++)
            begin
                if (pinS2[i] == pinS3[i])
                begin
                    pinLvl[i] <= pinS3[i];
                end
            end
            sclkPrev <= pinLvl[PIN_SCLK];
        end
    end

    assign selected    = ~pinLvl[PIN_CSN];
    assign sclkRise    = selected & pinLvl[PIN_SCLK] & ~sclkPrev;
    assign sclkFall    = selected & ~pinLvl[PIN_SCLK] & sclkPrev;
    assign byteDone    = sclkRise & (bitCnt == 3'h7);
    assign byteValue   = {shiftIn, pinLvl[PIN_DIN]};
    assign cmdDone     = byteDone & (stateReg == ST_COMMAND);
    assign writeStrobe = byteDone & (stateReg == ST_DATA_WRITE);
    assign phaseNext   = cmdPhase(byteValue, |chenReg.channelAcceptFlags); // see R5

    // Bits are taken MSB first on the rising port clock; deselecting drops a partial byte.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || !selected)
        begin
            bitCnt  <= 3'h0;
            shiftIn <= 7'h00;
        end
        else if (sclkRise)
        begin
            bitCnt  <= bitCnt + 3'h1;
            shiftIn <= byteValue[6:0];
        end
    end

    // Every mapped command carries exactly one data byte.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || !selected)
        begin
            stateReg <= ST_COMMAND;
        end
        else if (byteDone)
        begin
            unique case (stateReg)
                ST_COMMAND:    stateReg <= phaseNext; // see R1
                ST_DATA_WRITE: stateReg <= ST_COMMAND;
                ST_DATA_READ:  stateReg <= ST_COMMAND;
                ST_IGNORE:     stateReg <= ST_COMMAND;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            cmdReg <= 8'h00;
        end
        else if (cmdDone)
        begin
            cmdReg <= byteValue;
        end
    end

    // Register writes on the last data bit.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            slotReg <= cgcc_slot_type'(SLOT_RST); // see R4
            cfgReg  <= cgcc_cfg_type'(CFG_RST);
            chenReg <= cgcc_chen_type'(CHEN_RST); // see R15
            aisnReg <= cgcc_impedance_scaling_coef_type'(IMPEDANCE_SCALING_COEF_RST);
            slicReg <= cgcc_slic_type'(SLIC_RST);
            dirReg  <= DIR_RST; // see R23
        end
        else if (writeStrobe)
        begin
            unique case (cmdReg)
                CMD_SLOT_WR: slotReg <= cgcc_slot_type'(byteValue); // see R1
                CMD_CFG_WR:  cfgReg  <= cgcc_cfg_type'(byteValue); // see R11
                CMD_CHEN_WR: chenReg <= cgcc_chen_type'(byteValue & CHEN_MASK);
                CMD_IMPEDANCE_SCALING_COEF_WR: aisnReg <= cgcc_impedance_scaling_coef_type'(byteValue & IMPEDANCE_SCALING_COEF_MASK);
                CMD_SLIC_WR: slicReg <= cgcc_slic_type'(byteValue & SLIC_MASK); // see R21
                CMD_DIR_WR:  dirReg  <= byteValue[4:0]; // see R23
                default:     dirReg  <= dirReg;
            endcase
        end
    end

    // Real-time byte: channel y puts input A at bit 2y and input B just above it.
    always_comb
    begin
        rtdValue = 8'h00;
        for (int y = 0; y < 4; y++)
        begin
            rtdValue[2 * y]     = debouncedInputA[y]; // see R17
            rtdValue[2 * y + 1] = secondInputB[y];
        end
    end

    always_comb
    begin
        unique case (byteValue)
            CMD_SLOT_RD:             readValue = slotReg;
            CMD_CFG_RD:              readValue = cfgReg;
            CMD_CHEN_RD:             readValue = chenReg & CHEN_MASK;
            CMD_IMPEDANCE_SCALING_COEF_RD:             readValue = aisnReg & IMPEDANCE_SCALING_COEF_MASK;
            CMD_SLIC_RD:             readValue = slicReg & SLIC_MASK;
            CMD_DIR_RD:              readValue = {3'h0, dirReg};
            CMD_RTD_RD, CMD_RTD_CLR: readValue = rtdValue; // see R16
            default:                 readValue = 8'h00;
        endcase
    end

    // Read data is loaded at the command's last bit and moves on falling port clocks, so the
    // first bit is already valid when the host samples on its first rising clock.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || !selected)
        begin
            txShift        <= 7'h00;
            skipFall       <= 1'b0;
            portDataOut    <= 1'b0;
            portDataOutEnN <= 1'b1;
        end
        else if (cmdDone && phaseNext == ST_DATA_READ)
        begin
            txShift        <= readValue[6:0];
            portDataOut    <= readValue[7];
            portDataOutEnN <= 1'b0;
            skipFall       <= 1'b1;
        end
        else if (byteDone && stateReg == ST_DATA_READ)
        begin
            portDataOutEnN <= 1'b1;
        end
        else if (sclkFall && stateReg == ST_DATA_READ)
        begin
            if (skipFall)
            begin
                skipFall <= 1'b0;
            end
            else
            begin
                portDataOut <= txShift[6];
                txShift     <= {txShift[5:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            irqClearPulse <= 1'b0;
        end
        else
        begin
            irqClearPulse <= cmdDone && byteValue == CMD_RTD_CLR; // see R16
        end
    end

    // Chopper: a fractional accumulator gives 2048 kHz ticks, then a divide by 8 or 7.
    assign chopSum  = chopAcc + CHOP_STEP;
    assign baseTick = chopSum >= CHOP_WRAP;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            chopAcc     <= 17'h00000;
            chopCnt     <= 3'h0;
            chopperClk  <= 1'b0;
            chopperTick <= 1'b0;
        end
        else
        begin
            chopAcc     <= baseTick ? chopSum - CHOP_WRAP : chopSum;
            chopperTick <= 1'b0;
            if (baseTick)
            begin
                if (chopCnt >= (cfgReg.chopperRateSel ? CHOP_LAST_FAST : CHOP_LAST_SLOW)) // see R7
                begin
                    chopCnt     <= 3'h0;
                    chopperTick <= 1'b1;
                end
                else
                begin
                    chopCnt <= chopCnt + 3'h1;
                end
                chopperClk <= chopCnt < 3'h3;
            end
        end
    end

    // PCM and global clock controls.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            txBothHighways     <= 1'b0;
            txLaunchRising     <= 1'b0;
            rxClockSlot        <= 3'h0;
            txClockSlot        <= 3'h0;
            irqOpenDrain       <= 1'b1;
            pcmSignalingOn     <= 1'b0;
            masterFromBitClock <= 1'b1;
            e1MuxPermitted     <= 1'b0;
            masterFreqKhz      <= 14'h0000;
            masterFreqValid    <= 1'b0;
        end
        else
        begin
            txBothHighways     <= slotReg.txBothHighways; // see R2
            txLaunchRising     <= slotReg.txLaunchEdge; // see R3
            rxClockSlot        <= slotReg.rxClockSlot; // see R4
            txClockSlot        <= slotReg.txClockSlot;
            irqOpenDrain       <= cfgReg.irqOutputType; // see R6
            pcmSignalingOn     <= cfgReg.pcmSignalingSel; // see R8
            masterFromBitClock <= cfgReg.clockSourceSel; // see R9
            e1MuxPermitted     <= cfgReg.clockSourceSel & e1MuxEnable; // see R9
            masterFreqKhz      <= freqDecode(cfgReg.masterFreqSel); // see R10
            masterFreqValid    <= freqDecode(cfgReg.masterFreqSel) != 14'h0000;
        end
    end

    // Channel and analog controls.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            channelAcceptFlags    <= 4'hF;
            robbedSignalingActive <= 1'b0;
            lowPowerActive        <= 1'b0;
            analogOutputToRef     <= 4'hF;
            analogOutputHiZ       <= 4'h0;
            txGainBoost           <= 1'b0;
            rxLossInsert          <= 1'b0;
            aisnGainSteps         <= 6'sh00;
            aisnCutoff            <= 1'b1;
            digitalLoopback       <= 1'b0;
        end
        else
        begin
            channelAcceptFlags    <= chenReg.channelAcceptFlags; // see R15
            robbedSignalingActive <= chenReg.robbedSignalingOn & muLawSelected; // see R12
            lowPowerActive        <= chenReg.lowPowerOn & ~|channelActive; // see R14
            analogOutputToRef     <= ~channelActive & {4{~chenReg.idleOutputStyle}}; // see R13
            analogOutputHiZ       <= ~channelActive & {4{chenReg.idleOutputStyle}};
            txGainBoost           <= aisnReg.transmitAnalogGain; // see R18
            rxLossInsert          <= aisnReg.rxAnalogLoss;
            // A zero field cuts the path, so the formula is not applied to it.
            if (aisnReg.impedanceScalingCoef == IMPEDANCE_SCALING_COEF_CUTOFF) // see R20
            begin
                aisnGainSteps <= 6'sh00;
            end
            else
            begin
                aisnGainSteps <= $signed({1'b0, aisnReg.impedanceScalingCoef} - IMPEDANCE_SCALING_COEF_OFFSET); // see R19
            end
            aisnCutoff            <= aisnReg.impedanceScalingCoef == IMPEDANCE_SCALING_COEF_CUTOFF;
            digitalLoopback       <= aisnReg.impedanceScalingCoef == IMPEDANCE_SCALING_COEF_LOOPBACK; // see R20
        end
    end

    // SLIC pins; input-configured pins are released and their output bits held at zero.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            slicIoOut    <= 5'h00;
            slicIoEnN    <= 5'h1F;
            muxedOutputB <= 1'b0;
        end
        else
        begin
            slicIoOut    <= slicReg.slicIo & dirReg; // see R21
            slicIoEnN    <= ~dirReg; // see R23
            muxedOutputB <= slicReg.muxedOutputBOne & e1MuxEnable; // see R22
        end
    end

    default clocking cbClk @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence sClearCmd;
        cmdDone && byteValue == CMD_RTD_CLR;
    endsequence

    sequence sOnePulse;
        irqClearPulse ##1 !irqClearPulse;
    endsequence

    AST_SLOT_GATED: assert property (cmdDone && byteValue == CMD_SLOT_WR && chenReg.channelAcceptFlags == 4'h0 |=> stateReg == ST_IGNORE) // see R5
        else $error("Clock-slot write accepted with no channel enabled.");
    AST_SLOT_WRITE: assert property (writeStrobe && cmdReg == CMD_SLOT_WR |=> slotReg == $past(byteValue) ##1 txClockSlot == $past(byteValue[2:0], 2)) // see R1
        else $error("Clock-slot write did not reach the slot outputs.");
    AST_CFG_WRITE: assert property (cmdDone && byteValue == CMD_CFG_WR |=> stateReg == ST_DATA_WRITE) // see R11
        else $error("Configuration write was gated.");
    AST_CLEAR_PULSE: assert property (sClearCmd |=> sOnePulse) // see R16
        else $error("Clear command did not give one clear pulse.");
    AST_KEEP_IRQ: assert property (cmdDone && byteValue == CMD_RTD_RD |=> !irqClearPulse) // see R16
        else $error("Plain real-time read cleared the interrupt.");
    AST_ROBBED: assert property (robbedSignalingActive |-> $past(chenReg.robbedSignalingOn && muLawSelected)) // see R12
        else $error("Robbed-bit signaling active without mu-law.");
    AST_LOW_POWER: assert property (lowPowerActive |-> $past(channelActive) == 4'h0) // see R14
        else $error("Low power entered while a channel was active.");
    AST_LOOPBACK: assert property (digitalLoopback |-> aisnGainSteps == 6'sh00 && !aisnCutoff) // see R20
        else $error("Loopback code did not give zero scaling gain.");
    AST_PIN_DIR: assert property (##1 slicIoEnN == ~$past(dirReg) && (slicIoOut & ~$past(dirReg)) == 5'h00) // see R21
        else $error("SLIC pin driven while configured as input.");
    AST_MUX_B: assert property (!e1MuxEnable |=> !muxedOutputB) // see R22
        else $error("Muxed second output driven without E1 mode.");
    AST_OPEN_DRAIN: assert property ($changed(cfgReg.irqOutputType) |=> irqOpenDrain == $past(cfgReg.irqOutputType)) // see R6
        else $error("Interrupt output type did not follow its bit.");

endmodule

// ===== cgcc_pkg.sv
/*
 * Shared constants and types of the codec global configuration command block.
 * Assumes a single 100 MHz system clock and a host that speaks the serial command port.
 */
package cgcc_pkg;

    // Command bytes; bit 0 selects read (1) or write (0).
    localparam logic [7:0] CMD_SLOT_WR    = 8'h44;
    localparam logic [7:0] CMD_SLOT_RD    = 8'h45;
    localparam logic [7:0] CMD_CFG_WR     = 8'h46;
    localparam logic [7:0] CMD_CFG_RD     = 8'h47;
    localparam logic [7:0] CMD_CHEN_WR    = 8'h4A;
    localparam logic [7:0] CMD_CHEN_RD    = 8'h4B;
    localparam logic [7:0] CMD_RTD_RD     = 8'h4D;
    localparam logic [7:0] CMD_RTD_CLR    = 8'h4F;
    localparam logic [7:0] CMD_IMPEDANCE_SCALING_COEF_WR    = 8'h50;
    localparam logic [7:0] CMD_IMPEDANCE_SCALING_COEF_RD    = 8'h51;
    localparam logic [7:0] CMD_SLIC_WR    = 8'h52;
    localparam logic [7:0] CMD_SLIC_RD    = 8'h53;
    localparam logic [7:0] CMD_DIR_WR     = 8'h54;
    localparam logic [7:0] CMD_DIR_RD     = 8'h55;

    // Reset values.
    localparam logic [7:0] SLOT_RST       = 8'h00;
    localparam logic [7:0] CFG_RST        = 8'h9A;
    localparam logic [7:0] CHEN_RST       = 8'h0F;
    localparam logic [7:0] IMPEDANCE_SCALING_COEF_RST       = 8'h00;
    localparam logic [7:0] SLIC_RST       = 8'h00;
    localparam logic [4:0] DIR_RST        = 5'h00;

    // Field masks that force reserved bits to read as zero.
    localparam logic [7:0] CHEN_MASK      = 8'h7F;
    localparam logic [7:0] IMPEDANCE_SCALING_COEF_MASK      = 8'h7F;
    localparam logic [7:0] SLIC_MASK      = 8'h3F;

    // Impedance scaling.
    localparam logic [5:0] IMPEDANCE_SCALING_COEF_OFFSET    = 6'h10;
    localparam logic [4:0] IMPEDANCE_SCALING_COEF_LOOPBACK  = 5'h10;
    localparam logic [4:0] IMPEDANCE_SCALING_COEF_CUTOFF    = 5'h00;

    // Master clock frequencies in kHz.
    localparam logic [13:0] FREQ_BASE_A   = 14'h0600;
    localparam logic [13:0] FREQ_BASE_B   = 14'h0608;
    localparam logic [13:0] FREQ_BASE_C   = 14'h0800;

    // Chopper clock: a 2048 kHz rate made from the system clock, then divided.
    localparam int          SYS_CLK_KHZ   = 100000;
    localparam int          CHOP_BASE_KHZ = 2048;
    localparam logic [16:0] CHOP_STEP     = 17'(CHOP_BASE_KHZ);
    localparam logic [16:0] CHOP_WRAP     = 17'(SYS_CLK_KHZ);
    localparam logic [2:0]  CHOP_LAST_SLOW = 3'h7;
    localparam logic [2:0]  CHOP_LAST_FAST = 3'h6;

    // Synchroniser bit positions of the port pins.
    localparam int PIN_DIN  = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_CSN  = 2;

    typedef struct packed {
        logic       txBothHighways;
        logic       txLaunchEdge;
        logic [2:0] rxClockSlot;
        logic [2:0] txClockSlot;
    } cgcc_slot_type;

    typedef struct packed {
        logic       irqOutputType;
        logic       chopperRateSel;
        logic       pcmSignalingSel;
        logic       clockSourceSel;
        logic [3:0] masterFreqSel;
    } cgcc_cfg_type;

    typedef struct packed {
        logic       reserved;
        logic       robbedSignalingOn;
        logic       idleOutputStyle;
        logic       lowPowerOn;
        logic [3:0] channelAcceptFlags;
    } cgcc_chen_type;

    typedef struct packed {
        logic       reserved;
        logic       transmitAnalogGain;
        logic       rxAnalogLoss;
        logic [4:0] impedanceScalingCoef;
    } cgcc_impedance_scaling_coef_type;

    typedef struct packed {
        logic [1:0] reserved;
        logic       muxedOutputBOne;
        logic [4:0] slicIo;
    } cgcc_slic_type;

    typedef enum logic [1:0] {
        ST_COMMAND,
        ST_DATA_WRITE,
        ST_DATA_READ,
        ST_IGNORE
    } cgcc_state_type;

endpackage

// ===== cgcc_host_model.sv
/*
 * Host model that sends one command byte and one data byte over the serial command port.
 * It assumes the 100 MHz bench clock. The port clock stands high between frames.
 */
`timescale 1ns/1ps
module cgcc_host_model
(
    // Clock and serial command port
    input  wire logic sys_clk,
    output logic      portSelectN = 1'b1,
    output logic      portClock   = 1'b1,
    output logic      portDataIn  = 1'b0,
    input  wire logic portDataOut,
    input  wire logic portDataOutEnN
);
    // Read bits are taken just before each rising port clock, when they have settled.
    task automatic xfer(input logic [15:0] s, output logic [7:0] rd);
        portSelectN = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (12) @(negedge sys_clk);
            portClock  = 1'b0;
            portDataIn = s[i];
            repeat (12) @(negedge sys_clk);
            // A released line reads as the inverse of its last level, so an undriven read cannot pass.
            rd[i % 8] = portDataOutEnN ? ~portDataOut : portDataOut;
            portClock = 1'b1;
        end
        repeat (12) @(negedge sys_clk);
        portSelectN = 1'b1;
        portDataIn  = ~portDataIn;
        // Stay deselected long enough for the block to see the end of the frame.
        repeat (12) @(negedge sys_clk);
    endtask
endmodule

// ===== codec_global_config_cmds_tb.sv
/*
 * Self-checking bench of the global configuration command block.
 * It assumes the host model on the serial port and a 100 MHz clock.
 */
`timescale 1ns/1ps
module codec_global_config_cmds_tb
    import cgcc_pkg::*;
;
    logic sys_clk = 1'b0, resetn = 1'b0, muLawSelected = 1'b1, e1MuxEnable = 1'b1;
    logic [3:0] channelActive = 4'h0, debouncedInputA = 4'hA, secondInputB = 4'h5;
    logic [4:0] slicIoIn = 5'h00;
    logic portSelectN, portClock, portDataIn, portDataOut, portDataOutEnN, muxedOutputB, txBothHighways;
    logic txLaunchRising, irqOpenDrain, pcmSignalingOn, masterFromBitClock, e1MuxPermitted, masterFreqValid;
    logic chopperClk, chopperTick, robbedSignalingActive, lowPowerActive, txGainBoost, rxLossInsert;
    logic aisnCutoff, digitalLoopback, irqClearPulse;
    logic [3:0] channelAcceptFlags, analogOutputToRef, analogOutputHiZ;
    logic [4:0] slicIoOut, slicIoEnN;
    logic [2:0] rxClockSlot, txClockSlot;
    logic [13:0] masterFreqKhz;
    logic signed [5:0] aisnGainSteps;
    logic [7:0] rv;
    int fail_count = 0, n_tests = 0, clr = 0;
    cgcc_top uut (.*);
    cgcc_host_model host (.sys_clk, .portSelectN, .portClock, .portDataIn, .portDataOut, .portDataOutEnN);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) clr <= clr + int'(irqClearPulse === 1'b1);
    task automatic chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp)
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        fail_count += int'(got !== exp);
    endtask
    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        host.xfer({c, d}, rv);
    endtask
    task automatic rdc(input logic [7:0] c, input logic [7:0] e);
        host.xfer({c, 8'h00}, rv);
        chk("read", rv, e);
    endtask
    task automatic t_regs();
        rdc(CMD_CFG_RD, CFG_RST);
        rdc(CMD_CHEN_RD, CHEN_RST);
        chk("reset", {irqOpenDrain, masterFreqKhz, channelAcceptFlags}, 20'h6000F);
        chk("idle", {masterFromBitClock, masterFreqValid, analogOutputToRef, portDataOutEnN}, 20'h7F);
        wr(CMD_SLOT_WR, 8'hC5);
        chk("slot", {txBothHighways, txLaunchRising, rxClockSlot, txClockSlot}, 20'hC5);
        wr(CMD_CHEN_WR, 8'h70);
        chk("mode", {channelAcceptFlags, robbedSignalingActive, lowPowerActive, analogOutputHiZ}, 20'h3F);
        wr(CMD_SLOT_WR, 8'h00);
        rdc(CMD_SLOT_RD, 8'hFF);
        wr(CMD_CFG_WR, 8'h71);
        chk("cfg", {irqOpenDrain, pcmSignalingOn, e1MuxPermitted, masterFreqKhz}, 20'hC608);
        wr(CMD_CHEN_WR, CHEN_RST);
        rdc(CMD_SLOT_RD, 8'hC5);
    endtask
    task automatic t_chop(input int e);
        int p = 0;
        int h = 0;
        while (chopperTick !== 1'b1) @(negedge sys_clk);
        do
        begin
            @(negedge sys_clk);
            p++;
            h += int'(chopperClk === 1'b1);
        end
        while (chopperTick !== 1'b1);
        chk("chop_period", (p * CHOP_BASE_KHZ + SYS_CLK_KHZ / 2) / SYS_CLK_KHZ, e);
        chk("chop_high", (h * CHOP_BASE_KHZ + SYS_CLK_KHZ / 2) / SYS_CLK_KHZ, 3);
    endtask
    task automatic t_misc();
        wr(CMD_CFG_WR, 8'h03);
        chk("freq", {masterFromBitClock, e1MuxPermitted, masterFreqValid, masterFreqKhz}, 20'h0);
        rdc(CMD_RTD_RD, 8'h66);
        rdc(CMD_RTD_CLR, 8'h66);
        chk("clears", clr, 20'h1);
        wr(CMD_IMPEDANCE_SCALING_COEF_WR, 8'h10);
        chk("loopback", {digitalLoopback, aisnCutoff, aisnGainSteps}, 20'h80);
        wr(CMD_IMPEDANCE_SCALING_COEF_WR, 8'h60);
        chk("gains", {txGainBoost, rxLossInsert, aisnCutoff, aisnGainSteps}, 20'h1C0);
        wr(CMD_IMPEDANCE_SCALING_COEF_WR, 8'h65);
        chk("scale", {txGainBoost, rxLossInsert, aisnCutoff, aisnGainSteps}, 20'h1B5);
        wr(CMD_DIR_WR, 8'h05);
        wr(CMD_SLIC_WR, 8'h3F);
        chk("slic", {muxedOutputB, slicIoOut, slicIoEnN}, 20'h4BA);
        e1MuxEnable = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("muxb", muxedOutputB, 20'h0);
    endtask
    initial
    begin
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        t_chop(8);
        t_regs();
        t_chop(7);
        t_misc();
        end_sim();
    end
    initial
    begin
        #200us;
        fail_count++;
        end_sim();
    end
endmodule
